/* rtl/ieu_pkg.sv */
// Shared constants and types of the instruction execute unit
package ieu_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int MEM_AW = 9;
    localparam int MEM_DEPTH = 384;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PW = 3;
    localparam int REG_AW = 3;

    // Register port offsets
    localparam logic [2:0] REG_ACC = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_CTRL = 3'h2;
    localparam logic [2:0] REG_PTR_LO = 3'h3;
    localparam logic [2:0] REG_PTR_HI = 3'h4;
    localparam logic [2:0] REG_MEM_DATA = 3'h5;
    localparam logic [2:0] REG_PC_LO = 3'h6;
    localparam logic [2:0] REG_PC_HI = 3'h7;

    // Status field positions
    localparam int ST_CARRY = 0;
    localparam int ST_HALF = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_OVF = 3;
    localparam int ST_PDOWN = 4;
    localparam int ST_WDTO = 5;

    // Reset values and ALU constants
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [12:0] PC_RST = 13'h0000;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [7:0] ONE = 8'h01;

    typedef enum logic [4:0] {
        OP_NOP, OP_DEC_MEM, OP_DEC_ACC, OP_INC_MEM, OP_INC_ACC, OP_HALT, OP_JUMP,
        OP_MOV_TO_ACC, OP_MOV_IMM, OP_MOV_TO_MEM, OP_OR_ACC, OP_OR_IMM, OP_OR_MEM,
        OP_RET, OP_RET_IMM, OP_RET_IRQ, OP_ROT_L_MEM, OP_ROT_L_ACC, OP_ROT_LC_MEM,
        OP_ROT_LC_ACC, OP_ROT_R_MEM, OP_ROT_R_ACC, OP_ROT_RC_MEM, OP_ROT_RC_ACC,
        OP_SUBB_ACC, OP_SUBB_MEM, OP_DSKIP_MEM, OP_DSKIP_ACC, OP_SET_BYTE, OP_SET_BIT
    } ieu_op_type;

    typedef enum logic [1:0] {
        ST_RUN, ST_DUMMY, ST_HALTED
    } ieu_state_type;

    typedef struct packed {
        ieu_op_type op;
        logic [MEM_AW-1:0] addr;
        logic [DATA_W-1:0] imm;
        logic [2:0] bitsel;
        logic [PC_W-1:0] target;
    } ieu_instr_type;

    typedef struct packed {
        logic [DATA_W-1:0] result;
        logic to_mem;
        logic to_acc;
        logic upd_zero;
        logic upd_carry;
        logic upd_arith;
        logic carry;
        logic half;
        logic ovf;
        logic skip;
    } ieu_alu_type;
endpackage : ieu_pkg

/* rtl/ieu_alu.sv */
// Combinational datapath of the execute unit
`timescale 1ns/1ps
`default_nettype none
module ieu_alu (
    input wire ieu_pkg::ieu_op_type op,
    input wire logic [7:0] acc,
    input wire logic [7:0] mem,
    input wire logic [7:0] imm,
    input wire logic [2:0] bitsel,
    input wire logic carry_in,
    output ieu_pkg::ieu_alu_type res
);
    import ieu_pkg::*;
    logic [8:0] diff;
    logic [4:0] ldiff;
    logic [7:0] dec_v;

    always_comb begin
        diff = {1'b0, acc} - {1'b0, mem} - {8'h00, ~carry_in};
        ldiff = {1'b0, acc[3:0]} - {1'b0, mem[3:0]} - {4'h0, ~carry_in};
        dec_v = mem - ONE;
        res = '0;
        case (op)
            // RULE_01 decrement, zero only
            OP_DEC_MEM, OP_DEC_ACC: begin
                res.result = dec_v;
                res.to_mem = (op == OP_DEC_MEM);
                res.to_acc = (op == OP_DEC_ACC);
                res.upd_zero = 1'b1;
            end
            // RULE_02 increment, zero only
            OP_INC_MEM, OP_INC_ACC: begin
                res.result = mem + ONE;
                res.to_mem = (op == OP_INC_MEM);
                res.to_acc = (op == OP_INC_ACC);
                res.upd_zero = 1'b1;
            end
            // RULE_05 moves, no flags
            OP_MOV_TO_ACC: begin
                res.result = mem;
                res.to_acc = 1'b1;
            end
            OP_MOV_IMM, OP_RET_IMM: begin
                res.result = imm;
                res.to_acc = 1'b1;
            end
            OP_MOV_TO_MEM: begin
                res.result = acc;
                res.to_mem = 1'b1;
            end
            // RULE_07 inclusive OR
            OP_OR_ACC, OP_OR_IMM, OP_OR_MEM: begin
                res.result = acc | ((op == OP_OR_IMM) ? imm : mem);
                res.to_mem = (op == OP_OR_MEM);
                res.to_acc = (op != OP_OR_MEM);
                res.upd_zero = 1'b1;
            end
            // RULE_11 rotate left
            OP_ROT_L_MEM, OP_ROT_L_ACC: begin
                res.result = {mem[6:0], mem[7]};
                res.to_mem = (op == OP_ROT_L_MEM);
                res.to_acc = (op == OP_ROT_L_ACC);
            end
            // RULE_12 rotate left via carry
            OP_ROT_LC_MEM, OP_ROT_LC_ACC: begin
                res.result = {mem[6:0], carry_in};
                res.carry = mem[7];
                res.upd_carry = 1'b1;
                res.to_mem = (op == OP_ROT_LC_MEM);
                res.to_acc = (op == OP_ROT_LC_ACC);
            end
            // RULE_13 rotate right
            OP_ROT_R_MEM, OP_ROT_R_ACC: begin
                res.result = {mem[0], mem[7:1]};
                res.to_mem = (op == OP_ROT_R_MEM);
                res.to_acc = (op == OP_ROT_R_ACC);
            end
            // RULE_14 rotate right via carry
            OP_ROT_RC_MEM, OP_ROT_RC_ACC: begin
                res.result = {carry_in, mem[7:1]};
                res.carry = mem[0];
                res.upd_carry = 1'b1;
                res.to_mem = (op == OP_ROT_RC_MEM);
                res.to_acc = (op == OP_ROT_RC_ACC);
            end
            // RULE_15 subtract with borrow
            OP_SUBB_ACC, OP_SUBB_MEM: begin
                res.result = diff[7:0];
                res.carry = ~diff[8];
                res.half = ~ldiff[4];
                res.ovf = (acc[7] != mem[7]) && (diff[7] != acc[7]);
                res.upd_zero = 1'b1;
                res.upd_carry = 1'b1;
                res.upd_arith = 1'b1;
                res.to_mem = (op == OP_SUBB_MEM);
                res.to_acc = (op == OP_SUBB_ACC);
            end
            // RULE_16 decrement and skip
            OP_DSKIP_MEM, OP_DSKIP_ACC: begin
                res.result = dec_v;
                res.skip = (dec_v == 8'h00);
                res.to_mem = (op == OP_DSKIP_MEM);
                res.to_acc = (op == OP_DSKIP_ACC);
            end
            // RULE_17 set whole byte
            OP_SET_BYTE: begin
                res.result = ALL_ONES;
                res.to_mem = 1'b1;
            end
            // RULE_18 set one bit
            OP_SET_BIT: begin
                res.result = mem | (ONE << bitsel);
                res.to_mem = 1'b1;
            end
            default: begin
                res = '0;
            end
        endcase
    end
endmodule : ieu_alu
`default_nettype wire

/* rtl/ieu_stack.sv */
// Return address stack
`timescale 1ns/1ps
`default_nettype none
module ieu_stack (
    input wire logic clk,
    input wire logic rstn,
    input wire logic push,
    input wire logic pop,
    input wire logic [12:0] din,
    output logic [12:0] top
);
    import ieu_pkg::*;
    typedef struct packed {
        logic [STACK_PW-1:0] ptr;
    } ieu_stk_type;
    ieu_stk_type s_reg;
    ieu_stk_type s_next;
    logic [PC_W-1:0] entry [STACK_DEPTH];

    // Pointer wraps silently on over- and underflow, as nesting is software's job
    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.ptr = s_reg.ptr + 3'h1;
        end else if (pop) begin
            s_next.ptr = s_reg.ptr - 3'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            entry[s_next.ptr] <= din;
        end
    end

    assign top = entry[s_reg.ptr];
endmodule : ieu_stack
`default_nettype wire

/* rtl/ieu_core.sv */
// Execute unit: accumulator, flags, data memory, program counter and halt
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE_01: decrement memory byte, only zero flag
// RULE_02: increment memory byte, only zero flag
// RULE_03: halt stops, clears watchdog, sets powerdown
// RULE_04: jump loads counter, takes two cycles
// RULE_05: moves between memory, immediate, accumulator; flags kept
// RULE_06: no-operation changes nothing, advances counter
// RULE_07: bitwise OR, result acc or memory
// RULE_08: return pops counter, flags kept
// RULE_09: return also loads accumulator with immediate
// RULE_10: irq return enables, pending irq first
// RULE_11: rotate left, bit 7 into 0
// RULE_12: rotate left through carry
// RULE_13: rotate right, bit 0 into 7
// RULE_14: rotate right through carry
// RULE_15: subtract with borrow, four arithmetic flags
// RULE_16: decrement, skip next when zero
// RULE_17: set byte to all ones
// RULE_18: set one selected bit only
// RULE_19: eight-bit values, wrap, zero of result
module ieu_core (
    input wire logic clk,
    input wire logic rstn,
    input wire ieu_pkg::ieu_instr_type instr,
    input wire logic instr_valid,
    output logic instr_ready,
    output logic [12:0] pc,
    output logic dummy_cycle,
    input wire logic irq_pending,
    input wire logic [12:0] irq_vector,
    output logic irq_taken,
    input wire logic wdt_timeout,
    input wire logic wake,
    output logic wdt_clear,
    output logic sys_clk_off,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    import ieu_pkg::*;

    typedef struct packed {
        ieu_state_type st;
        logic [DATA_W-1:0] acc;
        logic carry;
        logic half_carry_flag;
        logic zero;
        logic overflow_flag;
        logic powerdown_flag;
        logic watchdog_timeout_flag;
        logic global_irq_enable;
        logic [PC_W-1:0] pc;
        logic [MEM_AW-1:0] ptr;
        logic [DATA_W-1:0] rdata;
        logic wdt_clr;
        logic irq_tk;
    } ieu_core_type;

    ieu_core_type r_reg;
    ieu_core_type r_next;
    logic [DATA_W-1:0] dmem [MEM_DEPTH];
    logic [DATA_W-1:0] mem_rd;
    logic [DATA_W-1:0] ptr_rd;
    ieu_alu_type alu;
    logic exec;
    logic take_irq;
    logic stk_pop;
    logic [PC_W-1:0] stk_top;
    logic mem_we;
    logic [MEM_AW-1:0] mem_wa;
    logic [DATA_W-1:0] mem_wd;
    logic [7:0] status_rd;

    // Out-of-range addresses read as zero rather than wrapping
    assign mem_rd = (instr.addr < MEM_AW'(MEM_DEPTH)) ? dmem[instr.addr] : 8'h00;
    assign ptr_rd = (r_reg.ptr < MEM_AW'(MEM_DEPTH)) ? dmem[r_reg.ptr] : 8'h00;

    ieu_alu u_alu (
        .op(instr.op),
        .acc(r_reg.acc),
        .mem(mem_rd),
        .imm(instr.imm),
        .bitsel(instr.bitsel),
        .carry_in(r_reg.carry),
        .res(alu)
    );

    // RULE_10 pending irq served before next instruction
    assign take_irq = (r_reg.st == ST_RUN) && irq_pending && r_reg.global_irq_enable;
    assign instr_ready = (r_reg.st == ST_RUN) && !take_irq;
    assign exec = instr_ready && instr_valid;
    // RULE_08 pop on any return
    assign stk_pop = exec && (instr.op == OP_RET || instr.op == OP_RET_IMM
                              || instr.op == OP_RET_IRQ);

    ieu_stack u_stack (
        .clk(clk),
        .rstn(rstn),
        .push(take_irq),
        .pop(stk_pop),
        .din(r_reg.pc),
        .top(stk_top)
    );

    always_comb begin
        status_rd = 8'h00;
        status_rd[ST_CARRY] = r_reg.carry;
        status_rd[ST_HALF] = r_reg.half_carry_flag;
        status_rd[ST_ZERO] = r_reg.zero;
        status_rd[ST_OVF] = r_reg.overflow_flag;
        status_rd[ST_PDOWN] = r_reg.powerdown_flag;
        status_rd[ST_WDTO] = r_reg.watchdog_timeout_flag;
    end

    // Execution wins a memory write collision; the software write is dropped
    always_comb begin
        mem_we = 1'b0;
        mem_wa = instr.addr;
        mem_wd = alu.result;
        if (exec && alu.to_mem) begin
            mem_we = 1'b1;
        end else if (reg_wr && reg_addr == REG_MEM_DATA) begin
            mem_we = 1'b1;
            mem_wa = r_reg.ptr;
            mem_wd = reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (mem_we && mem_wa < MEM_AW'(MEM_DEPTH)) begin
            dmem[mem_wa] <= mem_wd;
        end
    end

    always_comb begin
        r_next = r_reg;
        r_next.wdt_clr = 1'b0;
        r_next.irq_tk = 1'b0;
        r_next.rdata = 8'h00;

        // Software access; instruction effects below override it
        if (reg_wr) begin
            case (reg_addr)
                REG_ACC: r_next.acc = reg_wdata;
                REG_STATUS: begin
                    r_next.carry = reg_wdata[ST_CARRY];
                    r_next.half_carry_flag = reg_wdata[ST_HALF];
                    r_next.zero = reg_wdata[ST_ZERO];
                    r_next.overflow_flag = reg_wdata[ST_OVF];
                    r_next.powerdown_flag = reg_wdata[ST_PDOWN];
                    r_next.watchdog_timeout_flag = reg_wdata[ST_WDTO];
                end
                REG_CTRL: r_next.global_irq_enable = reg_wdata[0];
                REG_PTR_LO: r_next.ptr[7:0] = reg_wdata;
                REG_PTR_HI: r_next.ptr[8] = reg_wdata[0];
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                REG_ACC: r_next.rdata = r_reg.acc;
                REG_STATUS: r_next.rdata = status_rd;
                REG_CTRL: r_next.rdata = {7'h00, r_reg.global_irq_enable};
                REG_PTR_LO: r_next.rdata = r_reg.ptr[7:0];
                REG_PTR_HI: r_next.rdata = {7'h00, r_reg.ptr[8]};
                REG_MEM_DATA: r_next.rdata = ptr_rd;
                REG_PC_LO: r_next.rdata = r_reg.pc[7:0];
                REG_PC_HI: r_next.rdata = {3'h0, r_reg.pc[12:8]};
                default: r_next.rdata = 8'h00;
            endcase
        end

        case (r_reg.st)
            ST_RUN: begin
                if (take_irq) begin
                    // Vector entry: return address pushed, further irqs masked
                    r_next.pc = irq_vector;
                    r_next.global_irq_enable = 1'b0;
                    r_next.irq_tk = 1'b1;
                    r_next.st = ST_DUMMY;
                end else if (exec) begin
                    // RULE_06 default advance, nothing else
                    r_next.pc = r_reg.pc + 13'h0001;
                    // RULE_19 eight-bit results, zero of result
                    if (alu.to_acc) begin
                        r_next.acc = alu.result;
                    end
                    if (alu.upd_zero) begin
                        r_next.zero = (alu.result == 8'h00);
                    end
                    // RULE_12 carry from shifted-out bit
                    if (alu.upd_carry) begin
                        r_next.carry = alu.carry;
                    end
                    // RULE_15 half carry and overflow
                    if (alu.upd_arith) begin
                        r_next.half_carry_flag = alu.half;
                        r_next.overflow_flag = alu.ovf;
                    end
                    case (instr.op)
                        // RULE_04 jump with dummy cycle
                        OP_JUMP: begin
                            r_next.pc = instr.target;
                            r_next.st = ST_DUMMY;
                        end
                        // RULE_09 return may also load acc
                        OP_RET, OP_RET_IMM: begin
                            r_next.pc = stk_top;
                            r_next.st = ST_DUMMY;
                        end
                        // RULE_10 re-enable irqs on return
                        OP_RET_IRQ: begin
                            r_next.pc = stk_top;
                            r_next.global_irq_enable = 1'b1;
                            r_next.st = ST_DUMMY;
                        end
                        // RULE_16 skip costs a dummy cycle
                        OP_DSKIP_MEM, OP_DSKIP_ACC: begin
                            if (alu.skip) begin
                                r_next.pc = r_reg.pc + 13'h0002;
                                r_next.st = ST_DUMMY;
                            end
                        end
                        // RULE_03 enter power down
                        OP_HALT: begin
                            r_next.powerdown_flag = 1'b1;
                            r_next.watchdog_timeout_flag = 1'b0;
                            r_next.wdt_clr = 1'b1;
                            r_next.st = ST_HALTED;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_DUMMY: begin
                r_next.st = ST_RUN;
            end
            ST_HALTED: begin
                // Counter already points past the halt, so wake resumes there
                if (wake) begin
                    r_next.st = ST_RUN;
                end
            end
            default: begin
                r_next.st = ST_RUN;
            end
        endcase

        // A timeout in the same cycle as a clear still sets the flag
        if (wdt_timeout) begin
            r_next.watchdog_timeout_flag = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r_reg <= '{st: ST_RUN, acc: ACC_RST, pc: PC_RST, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign pc = r_reg.pc;
    assign dummy_cycle = (r_reg.st == ST_DUMMY);
    assign irq_taken = r_reg.irq_tk;
    assign wdt_clear = r_reg.wdt_clr;
    // RULE_03 system clock gated while halted
    assign sys_clk_off = (r_reg.st == ST_HALTED);
    assign reg_rdata = r_reg.rdata;
endmodule : ieu_core
`default_nettype wire

/* test/ieu_core_sva.sv */
// Concurrent checks on the execute unit ports
`timescale 1ns/1ps
`default_nettype none
module ieu_core_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire ieu_pkg::ieu_instr_type instr,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire logic [12:0] pc,
    input wire logic dummy_cycle,
    input wire logic [12:0] irq_vector,
    input wire logic irq_taken,
    input wire logic wake,
    input wire logic wdt_clear,
    input wire logic sys_clk_off
);
    import ieu_pkg::*;
    logic take;
    assign take = instr_valid && instr_ready;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_jump_load: assert property (take && instr.op == OP_JUMP |=>
        pc == $past(instr.target) && dummy_cycle && !instr_ready) else $error("jump not loaded");
    a_dummy_stall: assert property (dummy_cycle |-> !instr_ready ##1 !dummy_cycle)
        else $error("request taken in dummy cycle");
    a_halt_stop: assert property (take && instr.op == OP_HALT |=>
        sys_clk_off && wdt_clear && !instr_ready) else $error("halt did not stop");
    a_halt_hold: assert property (sys_clk_off && !wake |=> sys_clk_off && $stable(pc))
        else $error("halted state left without wake");
    a_wake_run: assert property (sys_clk_off && wake |=> !sys_clk_off)
        else $error("wake ignored");
    a_clear_pulse: assert property (wdt_clear |=> !wdt_clear)
        else $error("watchdog clear too long");
    a_nop_step: assert property (take && instr.op == OP_NOP |=>
        pc == $past(pc) + 13'h1 && !dummy_cycle) else $error("nop step wrong");
    a_move_step: assert property (take && instr.op inside {OP_MOV_TO_ACC, OP_MOV_IMM,
        OP_MOV_TO_MEM} |=> pc == $past(pc) + 13'h1) else $error("move step wrong");
    a_skip_step: assert property (take && instr.op inside {OP_DSKIP_MEM, OP_DSKIP_ACC} |=>
        (pc == $past(pc) + 13'h1 && !dummy_cycle) || (pc == $past(pc) + 13'h2 && dummy_cycle))
        else $error("skip step wrong");
    a_ret_dummy: assert property (take && instr.op inside {OP_RET, OP_RET_IMM, OP_RET_IRQ}
        |=> dummy_cycle && !instr_ready) else $error("return without dummy");
    a_irq_vector: assert property (irq_taken |-> pc == $past(irq_vector) && dummy_cycle)
        else $error("irq entry wrong");
endmodule : ieu_core_sva
bind ieu_core ieu_core_sva i_ieu_core_sva (.clk(clk), .rstn(rstn), .instr(instr),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .pc(pc), .dummy_cycle(dummy_cycle),
    .irq_vector(irq_vector), .irq_taken(irq_taken), .wake(wake), .wdt_clear(wdt_clear),
    .sys_clk_off(sys_clk_off));
`default_nettype wire

/* test/ieu_prog_mem.sv */
// Program memory model feeding instructions by program counter
`timescale 1ns/1ps
`default_nettype none
module ieu_prog_mem (
    input wire logic [12:0] pc,
    input wire logic [12:0] stop_pc,
    output ieu_pkg::ieu_instr_type instr,
    output logic instr_valid
);
    import ieu_pkg::*;
    ieu_instr_type rom [512];
    // Fetching halts at stop_pc so the bench paces execution
    assign instr_valid = (pc != stop_pc);
    // Inverted word while idle so stale values never look valid
    assign instr = instr_valid ? rom[pc[8:0]] : ~rom[pc[8:0]];
    initial begin
        for (int i = 0; i < 512; i++) begin
            rom[i] = '0;
        end
    end
    task load(input logic [12:0] a, input ieu_instr_type w);
        rom[a[8:0]] = w;
    endtask : load
endmodule : ieu_prog_mem
`default_nettype wire

/* test/test_ieu_core.sv */
// Self-checking bench of the execute unit
`timescale 1ns/1ps
`default_nettype none
module test_ieu_core;
    import ieu_pkg::*;
    typedef struct packed {
        ieu_op_type op;
        logic [7:0] a, m, s, xa, xm, xs;
        logic [1:0] step;
    } ieu_case_type;
    logic clk, rstn, instr_valid, instr_ready, dummy_cycle, irq_pending, irq_taken;
    logic wdt_timeout, wake, wdt_clear, sys_clk_off, reg_wr, reg_rd;
    logic [12:0] pc, irq_vector, stop_pc, cur;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    ieu_instr_type instr;
    int mismatches = 0, tests_run = 0, n_taken = 0, n_clear = 0, k;
    ieu_case_type cases [28] = '{
        {OP_DEC_MEM, 48'h66_01_00_66_00_04, 2'h1},
        {OP_DEC_ACC, 48'h00_00_05_ff_00_01, 2'h1},
        {OP_INC_MEM, 48'h66_ff_01_66_00_05, 2'h1},
        {OP_INC_ACC, 48'h00_7f_04_80_7f_00, 2'h1},
        {OP_MOV_TO_ACC, 48'h00_3c_0f_3c_3c_0f, 2'h1},
        {OP_MOV_IMM, 48'h00_3c_0f_5a_3c_0f, 2'h1},
        {OP_MOV_TO_MEM, 48'ha5_00_04_a5_a5_04, 2'h1},
        {OP_OR_ACC, 48'h00_00_01_00_00_05, 2'h1},
        {OP_OR_IMM, 48'h81_00_04_db_00_00, 2'h1},
        {OP_OR_MEM, 48'h0f_f0_04_0f_ff_00, 2'h1},
        {OP_ROT_L_MEM, 48'h00_81_00_00_03_00, 2'h1},
        {OP_ROT_L_ACC, 48'h00_81_05_03_81_05, 2'h1},
        {OP_ROT_LC_MEM, 48'h66_80_00_66_00_01, 2'h1},
        {OP_ROT_LC_ACC, 48'h00_01_01_03_01_00, 2'h1},
        {OP_ROT_R_MEM, 48'h00_01_01_00_80_01, 2'h1},
        {OP_ROT_R_ACC, 48'h00_02_00_01_02_00, 2'h1},
        {OP_ROT_RC_MEM, 48'h66_01_00_66_00_01, 2'h1},
        {OP_ROT_RC_ACC, 48'h00_02_01_81_02_00, 2'h1},
        {OP_SUBB_ACC, 48'h10_01_01_0f_01_01, 2'h1},
        {OP_SUBB_ACC, 48'h80_00_00_7f_00_09, 2'h1},
        {OP_SUBB_MEM, 48'h05_05_01_05_00_07, 2'h1},
        {OP_SUBB_MEM, 48'h00_01_01_00_ff_00, 2'h1},
        {OP_DSKIP_MEM, 48'h66_01_00_66_00_00, 2'h2},
        {OP_DSKIP_MEM, 48'h00_05_04_00_04_04, 2'h1},
        {OP_DSKIP_ACC, 48'h55_01_00_00_01_00, 2'h2},
        {OP_SET_BYTE, 48'h00_12_04_00_ff_04, 2'h1},
        {OP_SET_BIT, 48'h00_41_0f_00_49_0f, 2'h1},
        {OP_NOP, 48'h3c_c3_3f_3c_c3_3f, 2'h1}};

    ieu_core i_ieu_core (.clk(clk), .rstn(rstn), .instr(instr), .instr_valid(instr_valid),
        .instr_ready(instr_ready), .pc(pc), .dummy_cycle(dummy_cycle),
        .irq_pending(irq_pending), .irq_vector(irq_vector), .irq_taken(irq_taken),
        .wdt_timeout(wdt_timeout), .wake(wake), .wdt_clear(wdt_clear),
        .sys_clk_off(sys_clk_off), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    ieu_prog_mem i_ieu_prog_mem (.pc(pc), .stop_pc(stop_pc), .instr(instr),
        .instr_valid(instr_valid));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (irq_taken === 1'b1) n_taken++;
        if (wdt_clear === 1'b1) n_clear++;
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [2:0] a, input logic [7:0] x);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, x);
    endtask : rd
    task setptr(input logic [8:0] a);
        wr(REG_PTR_LO, a[7:0]);
        wr(REG_PTR_HI, {7'h0, a[8]});
    endtask : setptr
    task waitpc(input logic [12:0] t);
        for (int i = 0; pc !== t && i < 40; i++) begin
            @(posedge clk);
            #1;
        end
        chk(pc, t);
    endtask : waitpc
    task run(input ieu_op_type op, input logic [12:0] t);
        i_ieu_prog_mem.load(cur, '{op, 9'h010, 8'h5a, 3'h3, t});
        @(posedge clk);
        stop_pc <= t;
        waitpc(t);
        cur = t;
    endtask : run
    // Service routine at the vector holds only the return under test
    task irq_ret(input ieu_op_type op, input int hold);
        i_ieu_prog_mem.load(irq_vector, '{op, 9'h0, 8'h77, 3'h0, 13'h0});
        wr(REG_CTRL, 8'h01);
        @(posedge clk);
        irq_pending <= 1'b1;
        repeat (hold) @(posedge clk);
        irq_pending <= 1'b0;
        waitpc(cur);
    endtask : irq_ret
    task test_done;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    // Whole sequence needs under two thousand cycles
    initial begin
        #500000;
        mismatches++;
        test_done();
    end
    initial begin
        rstn = 1'b0;
        {irq_pending, wdt_timeout, wake, reg_wr, reg_rd} = 5'h0;
        reg_addr = 3'h0;
        reg_wdata = 8'h0;
        irq_vector = 13'h0040;
        stop_pc = 13'h0;
        cur = 13'h0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        wr(REG_MEM_DATA, 8'h00);
        for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
        wr(REG_PC_LO, 8'h33);
        rd(REG_PC_LO, 8'h00);
        setptr(9'h180);
        wr(REG_MEM_DATA, 8'h55);
        rd(REG_MEM_DATA, 8'h00);
        setptr(9'h010);
        foreach (cases[j]) begin
            wr(REG_ACC, cases[j].a);
            wr(REG_STATUS, cases[j].s);
            wr(REG_MEM_DATA, cases[j].m);
            run(cases[j].op, cur + {11'h0, cases[j].step});
            rd(REG_ACC, cases[j].xa);
            rd(REG_STATUS, cases[j].xs);
            rd(REG_MEM_DATA, cases[j].xm);
        end
        run(OP_JUMP, 13'h0100);
        rd(REG_PC_HI, 8'h01);
        rd(REG_STATUS, 8'h3f);
        wr(REG_STATUS, 8'h0f);
        irq_ret(OP_RET_IMM, 2);
        rd(REG_ACC, 8'h77);
        wr(REG_ACC, 8'h11);
        irq_ret(OP_RET, 2);
        rd(REG_ACC, 8'h11);
        rd(REG_CTRL, 8'h00);
        k = n_taken;
        // Pending still high at the irq return forces a second entry
        irq_ret(OP_RET_IRQ, 6);
        chk(n_taken - k, 2);
        rd(REG_CTRL, 8'h01);
        rd(REG_STATUS, 8'h0f);
        @(posedge clk);
        wdt_timeout <= 1'b1;
        @(posedge clk);
        wdt_timeout <= 1'b0;
        rd(REG_STATUS, 8'h2f);
        k = n_clear;
        run(OP_HALT, cur + 13'h1);
        chk(sys_clk_off, 1);
        @(posedge clk);
        stop_pc <= cur + 13'h1;
        repeat (5) @(posedge clk);
        #1;
        chk(pc, cur);
        chk(n_clear - k, 1);
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        waitpc(cur + 13'h1);
        rd(REG_STATUS, 8'h1f);
        rd(REG_MEM_DATA, 8'hc3);
        test_done();
    end
endmodule : test_ieu_core
`default_nettype wire
